// ==== pkg/acr_cfg.svh ====
// Offsets, field positions, reset values and frame layout of the calibration registers
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

`define ACR_ADDR_W 15
`define ACR_OFF_CFG0 15'h0050
`define ACR_OFF_CFG1 15'h0051
`define ACR_OFF_BACK 15'h0057
`define ACR_OFF_PAT 15'h0058
`define ACR_OFF_VECTOR 15'h005A
`define ACR_OFF_STAT 15'h005B

`define ACR_RST_CFG0 8'h06
`define ACR_RST_CFG1 8'hF4
`define ACR_RST_BACK 8'h10
`define ACR_RST_PAT 8'h00
`define ACR_RST_VECTOR 8'h00
`define ACR_STAT_FIXED 8'h08

`define ACR_BIT_TSTAMP 5
`define ACR_BIT_VEC_EN 4
`define ACR_BIT_FG_TRIG 3
`define ACR_RANGE_HI 6
`define ACR_RANGE_LO 4
`define ACR_BIT_BG_RUN 1
`define ACR_BIT_BG_MODE 0
`define ACR_BIT_PATTERN 2
`define ACR_BIT_OVR 1
`define ACR_BIT_STOPPED 1
`define ACR_BIT_FIRST_DONE 0

`define ACR_FRAME_BITS 5'h18
`define ACR_HDR_BITS 5'h10

`endif

// ==== pkg/acr_pkg.sv ====
// Types shared by the calibration register block
package acr_pkg;

    typedef struct packed {
        logic timestamp_en;
        logic vector_access_en;
        logic [2:0] cal_signal_range_select;
        logic background_mode_enable;
        logic background_run_control;
        logic test_pattern_enable;
        logic overrange_enable;
    } acr_ctrl_s;

    typedef struct packed {
        logic rd_pulse;
        logic wr_pulse;
        logic [7:0] wr_data;
    } acr_vec_s;

    typedef enum logic [2:0] {
        ACR_IDLE = 3'b001,
        ACR_SHIFT = 3'b010,
        ACR_DONE = 3'b100
    } acr_spi_e;

endpackage : acr_pkg

// ==== design/acr_cal_regs.sv ====
// Calibration control registers behind the serial configuration port
`timescale 1ns/100ps
`default_nettype none
`include "acr_cfg.svh"

// Behaviour
// - Timestamp enable bit drives capture output
// - Vector enable routes 0x05A to scan chain
// - Trigger write pulses start, bit self-clears
// - Trigger also pulses state machine reset
// - Range field selects optimisation target
// - Only run bit and vector register writable during background
// - Run bit starts or pauses background
// - Mode bit enables background calibration
// - Trigger recovers incomplete calibration
// - Pattern and over-range enables drive outputs
// - Stopped flag reads 0 while running
// - First-calibration-done flag reads engine state
module acr_cal_regs
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial configuration port
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Calibration engine controls
    output acr_ctrl_s cal_ctrl,
    output logic fg_cal_start,
    output logic cal_sm_reset,
    // Calibration vector scan chain
    output acr_vec_s vec_port,
    input wire logic [7:0] vec_rd_data,
    // Calibration engine status
    input wire logic cal_running,
    input wire logic first_cal_done
);

    logic [2:0] sclk_sync_r;
    logic [2:0] scs_sync_r;
    logic [2:0] sdi_sync_r;
    logic sclk_f_r;
    logic scs_f_r;
    logic sdi_f_r;
    logic sclk_rise;
    logic sclk_fall;
    acr_spi_e spi_state_r;
    logic [4:0] bit_cnt_r;
    logic [23:0] rx_r;
    logic [23:0] rx_nxt;
    logic [7:0] tx_r;
    logic [7:0] cfg0_r;
    logic [7:0] cfg1_r;
    logic [7:0] back_r;
    logic [7:0] pat_r;
    logic [7:0] vector_r;
    logic bg_active;
    logic hdr_done;
    logic frame_done;
    logic is_read;
    logic [14:0] acc_addr;
    logic [7:0] wr_data;

    // Register read mux
    function automatic logic [7:0] read_value(input logic [14:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `ACR_OFF_CFG0: v = cfg0_r;
            `ACR_OFF_CFG1: v = cfg1_r;
            `ACR_OFF_BACK: v = back_r;
            `ACR_OFF_PAT: v = pat_r;
            `ACR_OFF_VECTOR: v = cfg0_r[`ACR_BIT_VEC_EN] ? vec_rd_data : vector_r;
            `ACR_OFF_STAT: v = `ACR_STAT_FIXED
                               | ({7'h00, ~cal_running} << `ACR_BIT_STOPPED)
                               | ({7'h00, first_cal_done} << `ACR_BIT_FIRST_DONE);
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    // Three-stage pin synchronisers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_sync_r <= 3'h0;
            scs_sync_r <= 3'h7;
            sdi_sync_r <= 3'h0;
        end
        else
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], sclk};
            scs_sync_r <= {scs_sync_r[1:0], scs_n};
            sdi_sync_r <= {sdi_sync_r[1:0], sdi};
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_f_r <= 1'b0;
            scs_f_r <= 1'b1;
            sdi_f_r <= 1'b0;
        end
        else
        begin
            if (sclk_sync_r[1] == sclk_sync_r[2])
                sclk_f_r <= sclk_sync_r[2];
            if (scs_sync_r[1] == scs_sync_r[2])
                scs_f_r <= scs_sync_r[2];
            if (sdi_sync_r[1] == sdi_sync_r[2])
                sdi_f_r <= sdi_sync_r[2];
        end
    end

    assign sclk_rise = (sclk_sync_r[1] == sclk_sync_r[2]) && sclk_sync_r[2] && !sclk_f_r;
    assign sclk_fall = (sclk_sync_r[1] == sclk_sync_r[2]) && !sclk_sync_r[2] && sclk_f_r;
    assign rx_nxt = {rx_r[22:0], sdi_f_r};
    assign hdr_done = (spi_state_r == ACR_SHIFT) && sclk_rise && !scs_f_r
                      && (bit_cnt_r == `ACR_HDR_BITS - 5'h01);
    assign frame_done = (spi_state_r == ACR_SHIFT) && sclk_rise && !scs_f_r
                        && (bit_cnt_r == `ACR_FRAME_BITS - 5'h01);
    assign is_read = rx_r[22];
    assign acc_addr = hdr_done ? rx_nxt[14:0] : rx_r[22:8];
    assign wr_data = rx_nxt[7:0];
    assign bg_active = back_r[`ACR_BIT_BG_MODE] && back_r[`ACR_BIT_BG_RUN];

    // Frame sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            spi_state_r <= ACR_IDLE;
            bit_cnt_r <= 5'h00;
            rx_r <= 24'h000000;
        end
        else
        begin
            case (spi_state_r)
                ACR_IDLE:
                begin
                    bit_cnt_r <= 5'h00;
                    if (!scs_f_r)
                        spi_state_r <= ACR_SHIFT;
                end
                ACR_SHIFT:
                begin
                    if (scs_f_r)
                        spi_state_r <= ACR_IDLE;
                    else if (sclk_rise)
                    begin
                        rx_r <= rx_nxt;
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (frame_done)
                            spi_state_r <= ACR_DONE;
                    end
                end
                ACR_DONE:
                begin
                    if (scs_f_r)
                        spi_state_r <= ACR_IDLE;
                end
                default: spi_state_r <= ACR_IDLE;
            endcase
        end
    end

    // Read data shifts out on falling clock edges
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_r <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            if (hdr_done && rx_r[14])
            begin
                tx_r <= read_value(rx_nxt[14:0]);
                sdo_oe <= 1'b1;
            end
            else if (sclk_fall && sdo_oe)
            begin
                sdo <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (scs_f_r)
                sdo_oe <= 1'b0;
        end
    end

    // Configuration register writes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg0_r <= `ACR_RST_CFG0;
            cfg1_r <= `ACR_RST_CFG1;
            back_r <= `ACR_RST_BACK;
            pat_r <= `ACR_RST_PAT;
        end
        else
        begin
            cfg0_r[`ACR_BIT_FG_TRIG] <= 1'b0;
            if (frame_done && !rx_r[22])
            begin
                case (rx_r[21:7])
                    `ACR_OFF_CFG0:
                    if (!bg_active)
                    begin
                        cfg0_r <= wr_data;
                    end
                    `ACR_OFF_CFG1:
                    if (!bg_active)
                        cfg1_r <= wr_data;
                    `ACR_OFF_BACK:
                    if (bg_active)
                        back_r[`ACR_BIT_BG_RUN] <= wr_data[`ACR_BIT_BG_RUN];
                    else
                        back_r <= wr_data;
                    `ACR_OFF_PAT:
                    if (!bg_active)
                        pat_r <= wr_data;
                    default: ;
                endcase
            end
        end
    end

    // Scan chain access through the vector register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vector_r <= `ACR_RST_VECTOR;
            vec_port <= '0;
        end
        else
        begin
            vec_port.rd_pulse <= 1'b0;
            vec_port.wr_pulse <= 1'b0;
            if (cfg0_r[`ACR_BIT_VEC_EN])
            begin
                if (hdr_done && rx_r[14] && rx_nxt[14:0] == `ACR_OFF_VECTOR)
                    vec_port.rd_pulse <= 1'b1;
                if (frame_done && !rx_r[22] && rx_r[21:7] == `ACR_OFF_VECTOR)
                begin
                    vec_port.wr_pulse <= 1'b1;
                    vec_port.wr_data <= wr_data;
                end
            end
            else if (frame_done && !rx_r[22] && rx_r[21:7] == `ACR_OFF_VECTOR)
                vector_r <= wr_data;
        end
    end

    // Outputs to the calibration engine
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cal_ctrl <= '0;
            fg_cal_start <= 1'b0;
            cal_sm_reset <= 1'b0;
        end
        else
        begin
            cal_ctrl.timestamp_en <= cfg0_r[`ACR_BIT_TSTAMP];
            cal_ctrl.vector_access_en <= cfg0_r[`ACR_BIT_VEC_EN];
            cal_ctrl.cal_signal_range_select <= cfg1_r[`ACR_RANGE_HI:`ACR_RANGE_LO];
            cal_ctrl.background_mode_enable <= back_r[`ACR_BIT_BG_MODE];
            cal_ctrl.background_run_control <= back_r[`ACR_BIT_BG_RUN];
            cal_ctrl.test_pattern_enable <= pat_r[`ACR_BIT_PATTERN];
            cal_ctrl.overrange_enable <= pat_r[`ACR_BIT_OVR];
            fg_cal_start <= cfg0_r[`ACR_BIT_FG_TRIG];
            // trigger also restarts after incomplete run
            cal_sm_reset <= cfg0_r[`ACR_BIT_FG_TRIG];
        end
    end

    logic unused_ok;
    assign unused_ok = is_read ^ ^acc_addr;

endmodule : acr_cal_regs
`default_nettype wire

// ==== testbench/acr_cal_regs_props.sv ====
// Assertion checker for the calibration register block
`timescale 1ns/100ps
`default_nettype none
module acr_cal_regs_props
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Serial port and block outputs
    input wire logic scs_n,
    input wire logic sdo_oe,
    input wire acr_ctrl_s cal_ctrl,
    input wire logic fg_cal_start,
    input wire logic cal_sm_reset,
    input wire acr_vec_s vec_port
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic lock;
    assign lock = cal_ctrl.background_mode_enable && cal_ctrl.background_run_control;
    sequence s_locked;
        lock ##1 lock;
    endsequence
    AST_START_PAIR: assert property (fg_cal_start |-> cal_sm_reset)
        else $error("start without state machine reset");
    AST_RESET_PAIR: assert property (cal_sm_reset |-> fg_cal_start)
        else $error("state machine reset without start");
    AST_START_PULSE: assert property (fg_cal_start |=> !fg_cal_start)
        else $error("start pulse longer than one cycle");
    AST_IDLE_HOLD: assert property (scs_n [*8] |-> $stable(cal_ctrl))
        else $error("controls changed outside a frame");
    AST_LOCK_MODE: assert property (lock |=> cal_ctrl.background_mode_enable)
        else $error("mode bit cleared while locked");
    AST_LOCK_FIELDS: assert property (s_locked |-> $stable({cal_ctrl.timestamp_en,
        cal_ctrl.vector_access_en, cal_ctrl.cal_signal_range_select,
        cal_ctrl.test_pattern_enable, cal_ctrl.overrange_enable}))
        else $error("config changed while locked");
    AST_LOCK_NO_TRIG: assert property (s_locked |-> !fg_cal_start)
        else $error("trigger accepted while locked");
    AST_VEC_GATE: assert property ((vec_port.rd_pulse || vec_port.wr_pulse)
        |-> cal_ctrl.vector_access_en)
        else $error("scan chain stepped while disabled");
    AST_VEC_ONE: assert property (vec_port.rd_pulse |=> !vec_port.rd_pulse)
        else $error("scan read pulse too long");
    AST_OE_IDLE: assert property (scs_n [*8] |-> !sdo_oe)
        else $error("output enable outside a frame");
endmodule : acr_cal_regs_props
bind acr_cal_regs acr_cal_regs_props acr_cal_regs_props_i (.clk(clk), .reset_n(reset_n),
    .scs_n(scs_n), .sdo_oe(sdo_oe), .cal_ctrl(cal_ctrl), .fg_cal_start(fg_cal_start),
    .cal_sm_reset(cal_sm_reset), .vec_port(vec_port));
`default_nettype wire

// ==== testbench/acr_cal_regs_tb_top.sv ====
// Self-checking bench for the calibration register block
`timescale 1ns/100ps
`default_nettype none
`include "acr_cfg.svh"
module acr_cal_regs_tb_top import acr_pkg::*;;
    logic clk = 0, reset_n = 0, sclk = 0, scs_n = 1, sdi = 0;
    logic cal_running = 0, first_cal_done = 0;
    logic [7:0] vec_rd_data = 8'h00, d, q;
    wire logic sdo, sdo_oe, fg_cal_start, cal_sm_reset;
    wire acr_ctrl_s cal_ctrl;
    wire acr_vec_s vec_port;
    int n_mismatch = 0, compares = 0, seed = 15, cyc = 0, n_fg = 0, n_rd = 0, n_wr = 0;
    acr_cal_regs acr_cal_regs_i (.clk(clk), .reset_n(reset_n), .sclk(sclk), .scs_n(scs_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .cal_ctrl(cal_ctrl), .fg_cal_start(fg_cal_start),
        .cal_sm_reset(cal_sm_reset), .vec_port(vec_port), .vec_rd_data(vec_rd_data),
        .cal_running(cal_running), .first_cal_done(first_cal_done));
    initial forever #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_fg <= n_fg + (fg_cal_start === 1'b1);
        n_rd <= n_rd + (vec_port.rd_pulse === 1'b1);
        n_wr <= n_wr + (vec_port.wr_pulse === 1'b1);
    end
    always @(negedge clk)
        if (cyc == 40000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    function automatic logic [8:0] exp_ctrl(input logic [7:0] c0, c1, bk, pt);
        return {c0[5], c0[4], c1[6:4], bk[0], bk[1], pt[2], pt[1]};
    endfunction : exp_ctrl
    task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic chk_cnt(input string nm, input int exp, input int got);
        compares++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_cnt
    // One frame: R/W bit, 15-bit address, data byte
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] w);
        logic [23:0] f;
        f = {rd, a, w};
        q = 8'h00;
        scs_n = 1'b0;
        for (int b = 23; b >= 0; b--)
        begin
            sdi = f[b];
            repeat (8) @(negedge clk);
            if (b < 8)
                q = {q[6:0], sdo};
            sclk = 1'b1;
            repeat (8) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        scs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : xfer
    task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
        xfer(1'b1, a, 8'h00);
        chk($sformatf("reg_%0h", a), {1'b0, exp}, {1'b0, q});
    endtask : rdchk
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        chk("range", 9'h070, cal_ctrl);
        rdchk(`ACR_OFF_CFG0, `ACR_RST_CFG0);
        rdchk(`ACR_OFF_CFG1, `ACR_RST_CFG1);
        rdchk(`ACR_OFF_BACK, `ACR_RST_BACK);
        rdchk(`ACR_OFF_PAT, `ACR_RST_PAT);
        rdchk(`ACR_OFF_VECTOR, `ACR_RST_VECTOR);
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            xfer(1'b0, `ACR_OFF_CFG0, d & 8'hE7);
            xfer(1'b0, `ACR_OFF_CFG1, d);
            xfer(1'b0, `ACR_OFF_PAT, d);
            xfer(1'b0, `ACR_OFF_VECTOR, d);
            rdchk(`ACR_OFF_CFG1, d);
            rdchk(`ACR_OFF_PAT, d);
            rdchk(`ACR_OFF_VECTOR, d);
            chk("ctrl", exp_ctrl(d & 8'hE7, d, 8'h10, d), cal_ctrl);
        end
        xfer(1'b0, `ACR_OFF_CFG0, 8'h08);
        chk_cnt("fg_start", 1, n_fg);
        rdchk(`ACR_OFF_CFG0, 8'h00);
        d = 8'($random(seed));
        xfer(1'b0, 15'h0059, d);
        rdchk(15'h0059, 8'h00);
        xfer(1'b0, `ACR_OFF_CFG0, 8'h10);
        vec_rd_data = 8'($random(seed));
        rdchk(`ACR_OFF_VECTOR, vec_rd_data);
        xfer(1'b0, `ACR_OFF_VECTOR, d);
        chk_cnt("vec_rd", 1, n_rd);
        chk("vec_wdata", {1'b0, d}, {1'b0, vec_port.wr_data});
        chk_cnt("vec_wr", 1, n_wr);
        for (int i = 0; i < 4; i++)
        begin
            {cal_running, first_cal_done} = 2'(i);
            rdchk(`ACR_OFF_STAT, {6'h02, ~cal_running, first_cal_done});
        end
        xfer(1'b0, `ACR_OFF_CFG0, 8'h00);
        xfer(1'b0, `ACR_OFF_PAT, 8'h00);
        xfer(1'b0, `ACR_OFF_BACK, 8'h13);
        chk("bg_on", 9'h00C, cal_ctrl & 9'h00C);
        xfer(1'b0, `ACR_OFF_PAT, 8'h06);
        rdchk(`ACR_OFF_PAT, 8'h00);
        xfer(1'b0, `ACR_OFF_CFG0, 8'h08);
        chk_cnt("fg_start", 1, n_fg);
        xfer(1'b0, `ACR_OFF_BACK, 8'h10);
        rdchk(`ACR_OFF_BACK, 8'h11);
        xfer(1'b0, `ACR_OFF_PAT, 8'h06);
        chk("pat", 9'h003, cal_ctrl & 9'h003);
        xfer(1'b0, `ACR_OFF_BACK, 8'h10);
        xfer(1'b0, `ACR_OFF_CFG0, 8'h08);
        chk_cnt("fg_start", 2, n_fg);
        tally_and_finish();
    end
endmodule : acr_cal_regs_tb_top
`default_nettype wire
